// >>> hw/cosl_blink_div.sv
// Divider making 1 Hz and 2 Hz square phases for the indicators.
// Assumes a single clock with synchronous high reset.
`timescale 1ns/1ps
module cosl_blink_div #(
	parameter int unsigned HALF1 = cosl_pkg::HALF1_CYC,
	parameter int unsigned HALF2 = cosl_pkg::HALF2_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Phases
	cosl_blink_if.src blk
);
	import cosl_pkg::*;

	// Elaboration check: each phase needs two cycles, and the fast phase must not be slower than the slow one
	if (HALF1 < 2 || HALF2 < 2 || HALF2 > HALF1) begin
		$error("cosl_blink_div: bad half periods");
	end

	typedef struct packed {
		logic [31:0] cnt1;
		logic [31:0] cnt2;
		logic ph1;
		logic ph2;
	} cosl_div_s;

	cosl_div_s st_ff;
	cosl_div_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.cnt1 = st_ff.cnt1 + 32'h1;
		nxt_st.cnt2 = st_ff.cnt2 + 32'h1;
		if (st_ff.cnt1 == 32'(HALF1 - 1)) begin
			nxt_st.cnt1 = 32'h0;
			nxt_st.ph1 = ~st_ff.ph1;
		end
		if (st_ff.cnt2 == 32'(HALF2 - 1)) begin
			nxt_st.cnt2 = 32'h0;
			nxt_st.ph2 = ~st_ff.ph2;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign blk.blink1 = st_ff.ph1;
	assign blk.blink2 = st_ff.ph2;
endmodule

// >>> hw/cosl_top.sv
// Start-up switch decode and status indicators of a CANopen gateway module.
// Assumes switch pins are asynchronous and protocol status inputs are on clk.
//
// How it works
// - Node address is tens switch times ten plus units switch.
// - Switch address is valid only from 1 through 99.
// - Address comes from switches or from the start-up init telegram.
// - Address is frozen once operation begins; later switch moves ignored.
// - Default PDO 3-8 identifiers exist only for addresses below 64.
// - Rate switch 1..8 maps 10k to 1M; settings 0 and 9 invalid.
// - Bit rate may instead come from the start-up init telegram.
// - Bit rate is frozen once operation begins.
// - State LED blinks green 1 Hz preop, 2 Hz prepared, steady operational.
// - State LED blinks red 1 Hz when bus initialisation failed.
// - Bus LED green 1 Hz on bus-off/passive, steady when running.
// - Bus LED red 1 Hz on other error, dark before initialised.
// - Indicator three driven dark; indicator four steady green when powered.
`timescale 1ns/1ps
module cosl_top #(
	parameter int unsigned HALF1 = cosl_pkg::HALF1_CYC,
	parameter int unsigned HALF2 = cosl_pkg::HALF2_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Rotary switch pins
	input wire logic [3:0] swAddrTens,
	input wire logic [3:0] swAddrUnits,
	input wire logic [3:0] swRate,
	// Start-up init telegram
	input wire logic initValid,
	input wire logic initAddrEn,
	input wire logic [6:0] initAddr,
	input wire logic initRateEn,
	input wire logic [3:0] initRate,
	// Protocol status
	input wire logic startOper,
	input wire logic busInit,
	input wire logic busInitFail,
	input wire cosl_pkg::cosl_node_e nodeState,
	input wire cosl_pkg::cosl_bus_e busState,
	// Held configuration
	output logic [6:0] nodeAddr,
	output logic addrValid,
	output logic pdoDefaultsOk,
	output cosl_pkg::cosl_rate_e bitRate,
	output logic rateValid,
	output logic configLocked,
	// Indicators
	output logic [5:0] ledGreen,
	output logic [5:0] ledRed
);
	import cosl_pkg::*;

	// Elaboration check: the divider cannot serve phases shorter than two cycles
	if (HALF1 < 2 || HALF2 < 2 || HALF2 > HALF1) begin
		$error("cosl_top: bad half periods");
	end

	cosl_blink_if blk ();

	cosl_blink_div #(
		.HALF1(HALF1),
		.HALF2(HALF2)
	) u_div (
		.clk(clk),
		.srst(srst),
		.blk(blk)
	);

	function automatic logic addrOk(input logic [6:0] a);
		return (a >= ADDR_MIN) && (a <= ADDR_MAX);
	endfunction

	function automatic logic rateOk(input logic [3:0] r);
		return (r >= RATE_SW_MIN) && (r <= RATE_SW_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [11:0] swMeta;
		logic [11:0] swSync;
		logic [1:0] startCnt;
		logic sampled;
		logic locked;
		logic [6:0] addr;
		logic aValid;
		logic [3:0] rate;
		logic rValid;
		logic pdo;
		logic [3:0] rateOut;
		logic [5:0] grn;
		logic [5:0] red;
	} cosl_top_s;

	cosl_top_s st_ff;
	cosl_top_s nxt_st;
	logic [6:0] swAddr;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_st = st_ff;
		swAddr = 7'(st_ff.swSync[11:8] * 7'd10) + 7'(st_ff.swSync[7:4]);
		// Two stages: rotary contacts are not on clk and may settle mid-cycle
		nxt_st.swMeta = {swAddrTens, swAddrUnits, swRate};
		nxt_st.swSync = st_ff.swMeta;

		// sample once, after synchroniser has filled
		if (!st_ff.sampled) begin
			if (st_ff.startCnt == 2'h2) begin
				nxt_st.sampled = 1'b1;
				nxt_st.addr = swAddr;
				// Digits above 9 give no valid address
				nxt_st.aValid = addrOk(swAddr) && (st_ff.swSync[11:8] <= DIGIT_MAX)
					&& (st_ff.swSync[7:4] <= DIGIT_MAX);
				nxt_st.rate = st_ff.swSync[3:0];
				nxt_st.rValid = rateOk(st_ff.swSync[3:0]);
			end else begin
				nxt_st.startCnt = st_ff.startCnt + 2'h1;
			end
		end

		// A telegram before capture would be overwritten by the switch sample, so it is ignored
		// telegram overrides during start-up only
		if (st_ff.sampled && !st_ff.locked && initValid) begin
			if (initAddrEn) begin
				nxt_st.addr = initAddr;
				nxt_st.aValid = addrOk(initAddr);
			end
			if (initRateEn) begin
				nxt_st.rate = initRate;
				nxt_st.rValid = rateOk(initRate);
			end
		end

		// Lock only gates the telegram from the next cycle, so one in the lock cycle lands
		// freeze address
		if (st_ff.sampled && startOper) begin
			nxt_st.locked = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////////
		// Derived outputs, registered so every pin comes from a flip-flop

		nxt_st.pdo = nxt_st.aValid && (nxt_st.addr < ADDR_PDO_LIMIT);
		nxt_st.rateOut = nxt_st.rValid ? nxt_st.rate : COSL_RATE_NONE;

		////////////////////////////////////////////////////////////////////////////////
		// Indicators; the blink phase is one cycle late, which no eye can see

		nxt_st.grn[0] = 1'b0;
		nxt_st.red[0] = 1'b0;
		if (busInitFail) begin
			nxt_st.red[0] = blk.blink1;
		end else begin
			case (nodeState)
				COSL_NODE_PREOP: nxt_st.grn[0] = blk.blink1;
				COSL_NODE_PREPARED: nxt_st.grn[0] = blk.blink2;
				COSL_NODE_OPER: nxt_st.grn[0] = 1'b1;
				default: nxt_st.grn[0] = 1'b0;
			endcase
		end

		nxt_st.grn[1] = 1'b0;
		nxt_st.red[1] = 1'b0;
		if (busInit) begin
			case (busState)
				COSL_BUS_RUN: nxt_st.grn[1] = 1'b1;
				COSL_BUS_PASSIVE: nxt_st.grn[1] = blk.blink1;
				COSL_BUS_OTHER: nxt_st.red[1] = blk.blink1;
				default: nxt_st.red[1] = blk.blink1;
			endcase
		end

		nxt_st.grn[5:2] = 4'h2;
		nxt_st.red[5:2] = 4'h0;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.addr <= ADDR_RST;
			st_ff.rate <= RATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all registered

	assign nodeAddr = st_ff.addr;
	assign addrValid = st_ff.aValid;
	assign pdoDefaultsOk = st_ff.pdo;
	assign bitRate = cosl_rate_e'(st_ff.rateOut);
	assign rateValid = st_ff.rValid;
	assign configLocked = st_ff.locked;
	assign ledGreen = st_ff.grn;
	assign ledRed = st_ff.red;
endmodule

// >>> inc/cosl_blink_if.sv
// Blink enables passed from the divider to the indicator logic.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cosl_blink_if;
	logic blink1;
	logic blink2;
	modport src (output blink1, output blink2);
	modport dst (input blink1, input blink2);
endinterface

// >>> inc/cosl_pkg.sv
// Constants and types for the CANopen switch decode and status indicator block.
// Assumes a 50 MHz clock; all counts derive from it.
package cosl_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned BLINK1_HZ = 1;
	localparam int unsigned BLINK2_HZ = 2;
	// Half periods in cycles
	localparam int unsigned HALF1_CYC = CLK_HZ / (2 * BLINK1_HZ);
	localparam int unsigned HALF2_CYC = CLK_HZ / (2 * BLINK2_HZ);
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [6:0] ADDR_MIN = 7'h01;
	localparam logic [6:0] ADDR_MAX = 7'h63;
	localparam logic [6:0] ADDR_PDO_LIMIT = 7'h40;
	localparam logic [3:0] RATE_SW_MIN = 4'h1;
	localparam logic [3:0] RATE_SW_MAX = 4'h8;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [3:0] RATE_RST = 4'h0;

	// Bit-rate codes
	typedef enum logic [3:0] {
		COSL_RATE_NONE = 4'h0,
		COSL_RATE_10K = 4'h1,
		COSL_RATE_20K = 4'h2,
		COSL_RATE_50K = 4'h3,
		COSL_RATE_125K = 4'h4,
		COSL_RATE_250K = 4'h5,
		COSL_RATE_500K = 4'h6,
		COSL_RATE_800K = 4'h7,
		COSL_RATE_1M = 4'h8
	} cosl_rate_e;

	// Node state reported by the protocol logic
	typedef enum logic [1:0] {
		COSL_NODE_PREOP = 2'h0,
		COSL_NODE_PREPARED = 2'h1,
		COSL_NODE_OPER = 2'h2
	} cosl_node_e;

	// Bus condition reported by the controller
	typedef enum logic [1:0] {
		COSL_BUS_RUN = 2'h0,
		COSL_BUS_PASSIVE = 2'h1,
		COSL_BUS_OTHER = 2'h2
	} cosl_bus_e;
endpackage

// >>> verif/canopen_switch_decode_led_status_tb.sv
// Bench for switch decode and status indicators.
// Assumes short blink half periods so whole blink cycles fit the run.
`timescale 1ns/1ps
module canopen_switch_decode_led_status_tb;
	import cosl_pkg::*;
	localparam int unsigned H1 = 8;
	localparam int unsigned H2 = 4;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] swAddrTens = 4'h0, swAddrUnits = 4'h0, swRate = 4'h0, initRate = 4'h0;
	logic initValid = 1'b0, initAddrEn = 1'b0, initRateEn = 1'b0, startOper = 1'b0;
	logic [6:0] initAddr = 7'h00, nodeAddr;
	logic [2:0] cond = 3'h0;
	cosl_node_e nodeState = COSL_NODE_PREOP;
	logic busInit, busInitFail, addrValid, pdoDefaultsOk, rateValid, configLocked;
	cosl_bus_e busState;
	cosl_rate_e bitRate;
	logic [5:0] ledGreen, ledRed;
	logic [11:0] leds;
	logic [15:0] cfg;
	int mismatches = 0;
	int checks_done = 0;
	logic [3:0] tensTab [10] = '{4'h0, 4'h0, 4'h9, 4'h6, 4'h6, 4'ha, 4'h1, 4'h2, 4'h3, 4'h9};
	logic [3:0] unitsTab [10] = '{4'h0, 4'h1, 4'h9, 4'h4, 4'h3, 4'h0, 4'h0, 4'h7, 4'h8, 4'hc};
	logic [2:0] bcTab [5] = '{3'h1, 3'h1, 3'h4, 3'h2, 3'h3};
	cosl_node_e bsTab [5] = '{COSL_NODE_PREOP, COSL_NODE_PREPARED, COSL_NODE_OPER, COSL_NODE_OPER, COSL_NODE_OPER};
	int bbTab [5] = '{0, 0, 6, 1, 7};
	int bhTab [5] = '{H1, H2, H1, H1, H1};
	assign leds = {ledRed, ledGreen};
	assign cfg = {1'b0, configLocked, rateValid, bitRate, pdoDefaultsOk, addrValid, nodeAddr};
	cosl_net_model u_cosl_net_model (.clk, .cond, .busInit, .busInitFail, .busState);
	cosl_top #(.HALF1(H1), .HALF2(H2)) u_cosl_top (.clk, .srst, .swAddrTens, .swAddrUnits, .swRate, .initValid,
		.initAddrEn, .initAddr, .initRateEn, .initRate, .startOper, .busInit, .busInitFail, .nodeState,
		.busState, .nodeAddr, .addrValid, .pdoDefaultsOk, .bitRate, .rateValid, .configLocked, .ledGreen, .ledRed);
	initial begin
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		if (mismatches == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic boot(input logic [3:0] t, input logic [3:0] u, input logic [3:0] r, input int hold);
		srst = 1'b1;
		{swAddrTens, swAddrUnits, swRate} = {t, u, r};
		cyc(hold);
		srst = 1'b0;
		cyc(5);
	endtask
	task automatic tele(input logic ae, input logic [6:0] a, input logic re, input logic [3:0] r, input logic so);
		{initValid, initAddrEn, initAddr, initRateEn, initRate, startOper} = {1'b1, ae, a, re, r, so};
		cyc(1);
		{initValid, startOper} = 2'b00;
		cyc(2);
	endtask
	// Address left unchecked when it is not valid
	task automatic cfgchk(input logic l, input logic [3:0] r, input logic [6:0] a);
		logic rv;
		logic av;
		logic [15:0] m;
		rv = r >= 4'h1 && r <= 4'h8;
		av = a >= 7'h01 && a <= 7'h63;
		m = av ? 16'hffff : 16'hff80;
		chk("cfg", {1'b0, l, rv, rv ? r : 4'h0, av && a < 7'h40, av, a} & m, cfg & m);
	endtask
	task automatic wt(input int b, input logic v);
		for (int i = 0; i < 40 && leds[b] !== v; i++) cyc(1);
	endtask
	// First high phase skipped: it may be cut short by the condition change
	task automatic blink(input int k);
		int n;
		cond = bcTab[k];
		nodeState = bsTab[k];
		wt(bbTab[k], 1'b1);
		wt(bbTab[k], 1'b0);
		wt(bbTab[k], 1'b1);
		n = 0;
		while (leds[bbTab[k]] === 1'b1 && n < 40) begin
			n++;
			cyc(1);
		end
		chk("blinkHalf", 16'(bhTab[k]), 16'(n));
	endtask
	initial begin
		#400000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		boot(4'h4, 4'h2, 4'h5, 10);
		chk("ledFixed", 16'h0008, 16'(leds & 12'hfbe));
		cfgchk(1'b0, 4'h5, 7'h2a);
		{swAddrTens, swAddrUnits, swRate} = 12'h991;
		cyc(4);
		cfgchk(1'b0, 4'h5, 7'h2a);
		tele(1'b1, 7'h46, 1'b1, 4'h8, 1'b0);
		cfgchk(1'b0, 4'h8, 7'h46);
		tele(1'b1, 7'h64, 1'b0, 4'h2, 1'b0);
		cfgchk(1'b0, 4'h8, 7'h64);
		tele(1'b1, 7'h05, 1'b1, 4'h3, 1'b1);
		cfgchk(1'b1, 4'h3, 7'h05);
		tele(1'b1, 7'h0a, 1'b1, 4'h6, 1'b0);
		cfgchk(1'b1, 4'h3, 7'h05);
		cond = 3'h1;
		nodeState = COSL_NODE_OPER;
		cyc(3 * H1);
		chk("steady", 16'h0003, 16'(leds & 12'h043));
		for (int k = 0; k < 5; k++) blink(k);
		for (int i = 0; i < 10; i++) begin
			boot(tensTab[i], unitsTab[i], 4'(i), 2);
			cfgchk(1'b0, 4'(i), 7'(tensTab[i] * 10 + unitsTab[i]));
		end
		report_and_stop();
	end
endmodule

// >>> verif/cosl_net_model.sv
// Model of the CAN network side that feeds bus status into the block.
// Assumes the bench picks one condition; the model reports it a cycle late.
`timescale 1ns/1ps
module cosl_net_model (
	// Clock
	input wire logic clk,
	// Condition: 0 none, 1 run, 2 passive, 3 other error, 4 init failed
	input wire logic [2:0] cond,
	// Status
	output logic busInit,
	output logic busInitFail,
	output cosl_pkg::cosl_bus_e busState
);
	import cosl_pkg::*;
	always_ff @(posedge clk) begin
		busInit <= cond != 3'h0;
		busInitFail <= cond == 3'h4;
		busState <= cond == 3'h2 ? COSL_BUS_PASSIVE : cond == 3'h3 ? COSL_BUS_OTHER : COSL_BUS_RUN;
	end
endmodule

// >>> verif/cosl_top_assertions.sv
// Checker of held configuration and indicator outputs.
// Assumes it is bound to cosl_top and sees only its ports.
`timescale 1ns/1ps
module cosl_top_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Status
	input wire logic busInit,
	input wire logic busInitFail,
	input wire cosl_pkg::cosl_node_e nodeState,
	input wire cosl_pkg::cosl_bus_e busState,
	// Outputs
	input wire logic [6:0] nodeAddr,
	input wire logic addrValid,
	input wire logic pdoDefaultsOk,
	input wire cosl_pkg::cosl_rate_e bitRate,
	input wire logic rateValid,
	input wire logic configLocked,
	input wire logic [5:0] ledGreen,
	input wire logic [5:0] ledRed
);
	import cosl_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_pdo; pdoDefaultsOk == (addrValid && nodeAddr < ADDR_PDO_LIMIT); endproperty
	a_pdo: assert property (p_pdo) else $error("pdo flag wrong");
	property p_range; addrValid |-> nodeAddr >= ADDR_MIN && nodeAddr <= ADDR_MAX; endproperty
	a_range: assert property (p_range) else $error("address out of range");
	property p_rate; rateValid ? bitRate inside {[RATE_SW_MIN:RATE_SW_MAX]} : bitRate == COSL_RATE_NONE; endproperty
	a_rate: assert property (p_rate) else $error("rate code wrong");
	property p_frz; configLocked |=> configLocked && $stable(nodeAddr) && $stable(bitRate); endproperty
	a_frz: assert property (p_frz) else $error("config moved");
	property p_fix; !srst |=> ledGreen[3] && !ledGreen[2] && !ledRed[2]; endproperty
	a_fix: assert property (p_fix) else $error("fixed led wrong");
	property p_oper; nodeState == COSL_NODE_OPER && !busInitFail |=> ledGreen[0] && !ledRed[0]; endproperty
	a_oper: assert property (p_oper) else $error("state led not steady");
	property p_fail; busInitFail |=> !ledGreen[0]; endproperty
	a_fail: assert property (p_fail) else $error("state led green on fail");
	property p_dark; !busInit |=> !ledGreen[1] && !ledRed[1]; endproperty
	a_dark: assert property (p_dark) else $error("bus led lit");
	property p_run; busInit && busState == COSL_BUS_RUN |=> ledGreen[1] && !ledRed[1]; endproperty
	a_run: assert property (p_run) else $error("bus led not steady");
	cover property (configLocked);
	cover property ($rose(ledRed[1]));
	cover property (pdoDefaultsOk ##1 !pdoDefaultsOk);
endmodule
bind cosl_top cosl_top_assertions u_cosl_top_assertions (.clk, .srst, .busInit, .busInitFail, .nodeState, .busState,
	.nodeAddr, .addrValid, .pdoDefaultsOk, .bitRate, .rateValid, .configLocked, .ledGreen, .ledRed);
